// >>> hdl/flash_ctl_cfg.svh
// register offsets, field positions, codes and timing for the flash controller
// assumes a 25 MHz system clock and a 16 kB array in 512-byte pages
`ifndef FLASH_CTL_CFG_SVH
`define FLASH_CTL_CFG_SVH

`define CTL_OFS 8'h00
`define KEY_OFS 8'h04
`define STAT_OFS 8'h08
`define RSRC_OFS 8'h0c

`define CTL_WE_BIT 0
`define CTL_EE_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_KEY_OPEN_BIT 1
`define STAT_KEY_DEAD_BIT 2
`define STAT_ANY_LOCK_BIT 3
`define STAT_LOCK_LSB 8
`define RSRC_FERR_BIT 0

`define KEY_CODE1 8'ha5
`define KEY_CODE2 8'hf1
`define ERASED_BYTE 8'hff

`define FLASH_BYTES 16384
`define PAGE_BYTES 512
`define RSVD_BASE 16'h3e00
`define LOCK_ADDR 14'h3dff
`define LOCK_PAGE 5'h1e

`define CLK_PERIOD_NS 40
`define WRITE_TIME_NS 40000
`define ERASE_TIME_NS 10000000

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> hdl/flash_ctl_pkg.sv
// types shared by the flash program, erase and security controller
// assumes the constants of flash_ctl_cfg.svh
`default_nettype none
package flash_ctl_pkg;

   typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_DEAD} key_t;
   typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_PROG, ST_ERASE, ST_DEV} op_t;
   typedef enum logic [1:0] {V_OK, V_REFUSE, V_ERROR} verdict_t;
   typedef enum logic [1:0] {DBG_READ, DBG_WRITE, DBG_ERASE, DBG_DEV_ERASE}
      dbg_op_t;

   typedef struct packed {
      op_t fsm;
      key_t key;
      logic we;
      logic ee;
      logic [23:0] cnt;
      logic [13:0] op_addr;
      logic [7:0] op_data;
      logic op_dbg;
      logic [7:0] lock;
      logic err_flag;
      logic err_pulse;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic cr_ack;
      logic [7:0] cr_data;
      logic dbg_done;
      logic dbg_refused;
      logic [7:0] dbg_rdata;
      logic ram_wr;
      logic ram_rd;
      logic [15:0] ram_addr;
      logic [7:0] ram_wdata;
   } state_t;

endpackage
`default_nettype wire

// >>> hdl/flash_program_erase_security.sv
// flash program, erase and page security controller with AXI4-Lite registers
// assumes CPU and debug-port request logic run on CLK; flash array is inside
`include "flash_ctl_cfg.svh"
`default_nettype none

// Operation
// - programming only clears bits to zero
// - erase sets whole 512-byte page to 0xFF
// - ops self-timed, CPU stalled until done
// - key 0xA5 then 0xF1, any gap
// - wrong key order or value disables until reset
// - op before key accepted disables until reset
// - key relocks after every completed firmware op
// - write enable routes data-move writes to flash
// - write enable cleared only by software or reset
// - both enables plus key: erase addressed page
// - write enable only plus key: program one byte
// - data-move reads always go to data RAM
// - lock byte's complement locks pages from page 0
// - lock byte page locked when any bit zero
// - unlocked pages open to every access source
// - locked pages: error reset, debug refused, locked firmware ok
// - firmware lock-page erase errors; debug only if unlocked
// - changing written lock byte: error or refused
// - reserved area: firmware error, debug refused
// - refused debug access causes no reset
// - error reset sets flash error flag
module flash_program_erase_security
   import flash_ctl_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES =
      (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [7:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [7:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   input wire logic DM_WR,
   input wire logic DM_RD,
   input wire logic [15:0] DM_ADDR,
   input wire logic [7:0] DM_WDATA,
   output logic RAM_WR,
   output logic RAM_RD,
   output logic [15:0] RAM_ADDR,
   output logic [7:0] RAM_WDATA,
   input wire logic CR_REQ,
   input wire logic [15:0] CR_ADDR,
   output logic CR_ACK,
   output logic [7:0] CR_DATA,
   input wire logic [15:0] EXEC_ADDR,
   output logic STALL,
   output logic FLASH_ERR_RST,
   input wire logic DBG_REQ,
   input wire dbg_op_t DBG_OP,
   input wire logic [15:0] DBG_ADDR,
   input wire logic [7:0] DBG_WDATA,
   output logic DBG_READY,
   output logic DBG_DONE,
   output logic DBG_REFUSED,
   output logic [7:0] DBG_RDATA
);

   localparam int unsigned WRITE_CYC =
      (`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   // erase must also last long enough to walk every byte it clears
   localparam int unsigned ERASE_LIM =
      (ERASE_CYCLES > `PAGE_BYTES) ? ERASE_CYCLES : `PAGE_BYTES;
   localparam int unsigned DEV_LIM =
      (ERASE_CYCLES > `FLASH_BYTES) ? ERASE_CYCLES : `FLASH_BYTES;
   localparam logic [23:0] WRITE_END = 24'(WRITE_CYC - 1);
   localparam logic [23:0] ERASE_END = 24'(ERASE_LIM - 1);
   localparam logic [23:0] DEV_END = 24'(DEV_LIM - 1);
   localparam logic [23:0] PAGE_CNT = 24'(`PAGE_BYTES);
   localparam logic [23:0] ALL_CNT = 24'(`FLASH_BYTES);

   logic [7:0] mem [0:`FLASH_BYTES-1];
   logic rst_meta_q;
   logic rst_n_q;
   state_t s_q;
   state_t s_d;
   logic mem_we;
   logic [13:0] mem_waddr;
   logic [7:0] mem_wdata;

   function automatic logic page_locked(input logic [15:0] a,
                                        input logic [7:0] lk);
      logic any;
      any = (lk != `ERASED_BYTE);
      return ({3'h0, a[13:9]} < ~lk) || (a[13:9] == `LOCK_PAGE && any);
   endfunction

   function automatic verdict_t judge(input logic [15:0] a,
                                      input logic dbg,
                                      input logic exec_lk,
                                      input logic erase,
                                      input logic wr,
                                      input logic [7:0] wd,
                                      input logic [7:0] cur,
                                      input logic [7:0] lk);
      verdict_t bad;
      verdict_t v;
      bad = dbg ? V_REFUSE : V_ERROR;
      v = V_OK;
      if (a >= `RSVD_BASE)
         v = bad;
      else if (erase && a[13:9] == `LOCK_PAGE)
         v = dbg ? ((lk != `ERASED_BYTE) ? V_REFUSE : V_OK) : V_ERROR;
      else if (wr && a[13:0] == `LOCK_ADDR && cur != `ERASED_BYTE &&
               (cur & wd) != cur)
         v = bad;
      else if (page_locked(a, lk) && (dbg || !exec_lk))
         v = bad;
      return v;
   endfunction

   // reset released through two flops, asserted at once
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // array starts erased; contents survive every reset like real flash
   initial
   begin
      for (int i = 0; i < `FLASH_BYTES; i++)
         mem[i] = `ERASED_BYTE;
   end

   always @(posedge CLK)
   begin
      if (mem_we)
         mem[mem_waddr] <= mem_wdata;
   end

   assign AWREADY = !s_q.aw_got && !s_q.bvalid;
   assign WREADY = !s_q.w_got && !s_q.bvalid;
   assign BVALID = s_q.bvalid;
   assign BRESP = s_q.bresp;
   assign ARREADY = !s_q.rvalid;
   assign RVALID = s_q.rvalid;
   assign RDATA = s_q.rdata;
   assign RRESP = s_q.rresp;
   assign RAM_WR = s_q.ram_wr;
   assign RAM_RD = s_q.ram_rd;
   assign RAM_ADDR = s_q.ram_addr;
   assign RAM_WDATA = s_q.ram_wdata;
   assign CR_ACK = s_q.cr_ack;
   assign CR_DATA = s_q.cr_data;
   assign STALL = (s_q.fsm != ST_IDLE);
   assign FLASH_ERR_RST = s_q.err_pulse;
   assign DBG_READY = (s_q.fsm == ST_IDLE) && !DM_WR && !CR_REQ;
   assign DBG_DONE = s_q.dbg_done;
   assign DBG_REFUSED = s_q.dbg_refused;
   assign DBG_RDATA = s_q.dbg_rdata;

   always_comb
   begin
      logic err;
      logic done;
      logic exec_lk;
      verdict_t v;
      err = 1'b0;
      done = 1'b0;
      exec_lk = page_locked(EXEC_ADDR, s_q.lock);
      v = V_OK;
      s_d = s_q;
      s_d.err_pulse = 1'b0;
      s_d.cr_ack = 1'b0;
      s_d.dbg_done = 1'b0;
      s_d.ram_wr = 1'b0;
      s_d.ram_rd = 1'b0;
      mem_we = 1'b0;
      mem_waddr = s_q.op_addr;
      mem_wdata = `ERASED_BYTE;

      case (s_q.fsm)
         ST_LOAD:
         begin
            // a lock byte written since reset takes effect only here
            s_d.lock = mem[`LOCK_ADDR];
            s_d.fsm = ST_IDLE;
         end
         ST_IDLE:
         begin
            if (DM_RD)
            begin
               s_d.ram_rd = 1'b1;
               s_d.ram_addr = DM_ADDR;
            end
            if (DM_WR && !s_q.we)
            begin
               s_d.ram_wr = 1'b1;
               s_d.ram_addr = DM_ADDR;
               s_d.ram_wdata = DM_WDATA;
            end
            else if (DM_WR)
            begin
               if (s_q.key != KEY_OPEN)
                  s_d.key = KEY_DEAD;
               else
               begin
                  v = judge(DM_ADDR, 1'b0, exec_lk, s_q.ee, !s_q.ee, DM_WDATA,
                            mem[DM_ADDR[13:0]], s_q.lock);
                  if (v != V_OK)
                     err = 1'b1;
                  else
                  begin
                     s_d.fsm = s_q.ee ? ST_ERASE : ST_PROG;
                     s_d.op_addr = DM_ADDR[13:0];
                     s_d.op_data = DM_WDATA;
                     s_d.op_dbg = 1'b0;
                     s_d.cnt = '0;
                  end
               end
            end
            else if (CR_REQ)
            begin
               v = judge(CR_ADDR, 1'b0, exec_lk, 1'b0, 1'b0, 8'h00, 8'h00,
                         s_q.lock);
               if (v != V_OK)
                  err = 1'b1;
               else
               begin
                  s_d.cr_ack = 1'b1;
                  s_d.cr_data = mem[CR_ADDR[13:0]];
               end
            end
            else if (DBG_REQ)
            begin
               v = judge(DBG_ADDR, 1'b1, 1'b0, DBG_OP == DBG_ERASE,
                         DBG_OP == DBG_WRITE, DBG_WDATA,
                         mem[DBG_ADDR[13:0]], s_q.lock);
               s_d.op_addr = DBG_ADDR[13:0];
               s_d.op_data = DBG_WDATA;
               s_d.op_dbg = 1'b1;
               s_d.cnt = '0;
               s_d.dbg_refused = 1'b0;
               if (DBG_OP == DBG_DEV_ERASE)
                  s_d.fsm = ST_DEV;
               else if (v != V_OK)
               begin
                  s_d.dbg_done = 1'b1;
                  s_d.dbg_refused = 1'b1;
               end
               else if (DBG_OP == DBG_READ)
               begin
                  s_d.dbg_done = 1'b1;
                  s_d.dbg_rdata = mem[DBG_ADDR[13:0]];
               end
               else
                  s_d.fsm = (DBG_OP == DBG_ERASE) ? ST_ERASE : ST_PROG;
            end
         end
         ST_PROG:
         begin
            s_d.cnt = s_q.cnt + 24'h1;
            if (s_q.cnt == WRITE_END)
            begin
               mem_we = 1'b1;
               mem_wdata = mem[s_q.op_addr] & s_q.op_data;
               done = 1'b1;
            end
         end
         ST_ERASE:
         begin
            s_d.cnt = s_q.cnt + 24'h1;
            mem_we = (s_q.cnt < PAGE_CNT);
            mem_waddr = {s_q.op_addr[13:9], s_q.cnt[8:0]};
            done = (s_q.cnt == ERASE_END);
         end
         ST_DEV:
         begin
            s_d.cnt = s_q.cnt + 24'h1;
            mem_we = (s_q.cnt < ALL_CNT);
            mem_waddr = s_q.cnt[13:0];
            done = (s_q.cnt == DEV_END);
         end
         default:
            s_d.fsm = ST_LOAD;
      endcase

      if (done)
      begin
         s_d.fsm = (s_q.fsm == ST_DEV) ? ST_LOAD : ST_IDLE;
         if (s_q.op_dbg)
            s_d.dbg_done = 1'b1;
         else if (s_q.key == KEY_OPEN)
            s_d.key = KEY_LOCKED;
      end

      // register bus: address and data in either order, answer after both
      if (AWVALID && !s_q.aw_got && !s_q.bvalid)
      begin
         s_d.aw_got = 1'b1;
         s_d.aw_addr = AWADDR;
      end
      if (WVALID && !s_q.w_got && !s_q.bvalid)
      begin
         s_d.w_got = 1'b1;
         s_d.w_data = WDATA;
         s_d.w_strb = WSTRB;
      end
      if (s_q.aw_got && s_q.w_got)
      begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = `RESP_OKAY;
         case (s_q.aw_addr & 8'hfc)
            `CTL_OFS:
               if (s_q.w_strb[0])
               begin
                  s_d.we = s_q.w_data[`CTL_WE_BIT];
                  s_d.ee = s_q.w_data[`CTL_EE_BIT];
               end
            `KEY_OFS:
               if (s_q.w_strb[0])
               begin
                  if (s_q.key == KEY_LOCKED && s_q.w_data[7:0] == `KEY_CODE1)
                     s_d.key = KEY_HALF;
                  else if (s_q.key == KEY_HALF &&
                           s_q.w_data[7:0] == `KEY_CODE2)
                     s_d.key = KEY_OPEN;
                  else
                     s_d.key = KEY_DEAD;
               end
            `STAT_OFS, `RSRC_OFS:
               s_d.bresp = `RESP_OKAY;
            default:
               s_d.bresp = `RESP_SLVERR;
         endcase
      end
      else if (s_q.bvalid && BREADY)
         s_d.bvalid = 1'b0;

      if (ARVALID && !s_q.rvalid)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = `RESP_OKAY;
         s_d.rdata = 32'h0;
         case (ARADDR & 8'hfc)
            `CTL_OFS:
            begin
               s_d.rdata[`CTL_WE_BIT] = s_q.we;
               s_d.rdata[`CTL_EE_BIT] = s_q.ee;
            end
            `KEY_OFS:
               s_d.rdata = 32'h0;
            `STAT_OFS:
            begin
               s_d.rdata[`STAT_BUSY_BIT] = (s_q.fsm != ST_IDLE);
               s_d.rdata[`STAT_KEY_OPEN_BIT] = (s_q.key == KEY_OPEN);
               s_d.rdata[`STAT_KEY_DEAD_BIT] = (s_q.key == KEY_DEAD);
               s_d.rdata[`STAT_ANY_LOCK_BIT] = (s_q.lock != `ERASED_BYTE);
               s_d.rdata[`STAT_LOCK_LSB +: 8] = s_q.lock;
            end
            `RSRC_OFS:
               s_d.rdata[`RSRC_FERR_BIT] = s_q.err_flag;
            default:
               s_d.rresp = `RESP_SLVERR;
         endcase
      end
      else if (s_q.rvalid && RREADY)
         s_d.rvalid = 1'b0;

      // error reset wins over any register write in the same cycle
      if (err)
      begin
         s_d.err_pulse = 1'b1;
         s_d.err_flag = 1'b1;
         s_d.key = KEY_LOCKED;
         s_d.we = 1'b0;
         s_d.ee = 1'b0;
         s_d.fsm = ST_LOAD;
      end
   end

   always_ff @(posedge CLK or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         s_q <= '0;
         s_q.fsm <= ST_LOAD;
         s_q.key <= KEY_LOCKED;
         s_q.lock <= `ERASED_BYTE;
      end
      else
         s_q <= s_d;
   end

endmodule
`default_nettype wire

// >>> tb/cpu_core_model.sv
// model of the cpu core issuing data-move and code-move requests
// assumes req is called just after a rising clk edge
`default_nettype none
module cpu_core_model
(
   input wire logic clk,
   input wire logic stall,
   input wire logic cr_ack,
   input wire logic [7:0] cr_data,
   output logic dm_wr,
   output logic dm_rd,
   output logic [15:0] dm_addr,
   output logic [7:0] dm_wdata,
   output logic cr_req,
   output logic [15:0] cr_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      dm_wr = 1'b0;
      dm_rd = 1'b0;
      cr_req = 1'b0;
      dm_addr = 16'h0000;
      dm_wdata = 8'h00;
      cr_addr = 16'h0000;
   end
   // k: 1 data write, 2 data read, 3 code read; q returns code data
   task automatic req(input logic [1:0] k, input logic [15:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      dm_wr <= k == 2'd1;
      dm_rd <= k == 2'd2;
      cr_req <= k == 2'd3;
      dm_addr <= a;
      cr_addr <= a;
      dm_wdata <= d;
      do @(posedge clk); while (stall);
      dm_wr <= 1'b0;
      dm_rd <= 1'b0;
      cr_req <= 1'b0;
      // released lines must not keep showing the old value
      dm_addr <= ~a;
      cr_addr <= ~a;
      dm_wdata <= ~d;
      q = 8'h00;
      repeat (3)
      begin
         @(posedge clk);
         if (cr_ack)
            q = cr_data;
      end
      while (stall) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// >>> tb/flash_ctl_monitor.sv
// port-level checker for the flash program, erase and security block
// assumes it is bound to the top module and sees its ports only
`default_nettype none
module flash_ctl_monitor
   import flash_ctl_pkg::*;
#(
   parameter int unsigned ERASE_CYCLES = 600
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic DM_WR,
   input wire logic DM_RD,
   input wire logic [15:0] DM_ADDR,
   input wire logic RAM_WR,
   input wire logic RAM_RD,
   input wire logic [15:0] RAM_ADDR,
   input wire logic CR_REQ,
   input wire logic CR_ACK,
   input wire logic STALL,
   input wire logic FLASH_ERR_RST,
   input wire logic DBG_REQ,
   input wire dbg_op_t DBG_OP,
   input wire logic DBG_READY,
   input wire logic DBG_DONE,
   input wire logic DBG_REFUSED
);
   timeunit 1ns;
   timeprecision 1ps;
   // longest busy spell is a device erase plus its lock reload
   localparam int SMAX =
      int'(ERASE_CYCLES > 16384 ? ERASE_CYCLES : 16384) + 8;
   logic [24:0] stall_q;
   logic [24:0] stall_d;
   always_comb stall_d = STALL ? stall_q + 25'h1 : 25'h0;
   always_ff @(posedge CLK or negedge RST_N)
      if (!RST_N)
         stall_q <= 25'h0;
      else
         stall_q <= stall_d;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_cr_take;
      CR_REQ && !STALL && !DM_WR;
   endsequence
   sequence s_dbg_rd;
      DBG_REQ && DBG_READY && DBG_OP == DBG_READ;
   endsequence
   property p_ram_rd;
      DM_RD && !DM_WR && !STALL |=> RAM_RD && RAM_ADDR == $past(DM_ADDR);
   endproperty
   property p_ram_wr;
      RAM_WR |-> $past(DM_WR) && RAM_ADDR == $past(DM_ADDR);
   endproperty
   property p_cr;
      s_cr_take |=> CR_ACK || FLASH_ERR_RST;
   endproperty
   property p_dbg_rd;
      s_dbg_rd |=> DBG_DONE;
   endproperty
   property p_dbg_ref;
      DBG_DONE && DBG_REFUSED |-> !FLASH_ERR_RST ##1 !FLASH_ERR_RST;
   endproperty
   property p_stall_rdy;
      STALL |-> !DBG_READY;
   endproperty
   property p_stall_ram;
      STALL && (DM_WR || DM_RD) |=> !RAM_WR && !RAM_RD;
   endproperty
   property p_stall_max;
      stall_q <= 25'(SMAX);
   endproperty
   property p_err_pulse;
      FLASH_ERR_RST |=> !FLASH_ERR_RST;
   endproperty
   a_ram_rd: assert property (p_ram_rd)
      else $error("data read not passed to ram");
   a_ram_wr: assert property (p_ram_wr)
      else $error("ram write without matching request");
   a_cr: assert property (p_cr)
      else $error("code read not answered");
   a_dbg_rd: assert property (p_dbg_rd)
      else $error("debug read not answered");
   a_dbg_ref: assert property (p_dbg_ref)
      else $error("refused debug access caused reset");
   a_stall_rdy: assert property (p_stall_rdy)
      else $error("debug ready while busy");
   a_stall_ram: assert property (p_stall_ram)
      else $error("request taken while busy");
   a_stall_max: assert property (p_stall_max)
      else $error("busy spell too long");
   a_err_pulse: assert property (p_err_pulse)
      else $error("error reset longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the flash program, erase and security block
// assumes the package, cfg header, checker and cpu model are compiled
`include "flash_ctl_cfg.svh"
`default_nettype none
module tb
   import flash_ctl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EC = 600;
   localparam logic [23:0] B1 = 24'hf1a55a;
   localparam logic [23:0] B2 = 24'ha500f1;
   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
   logic ARVALID = 1'b0, RREADY = 1'b0, DBG_REQ = 1'b0;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00, DBG_WDATA = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic [3:0] WSTRB = 4'hf;
   logic [15:0] EXEC_ADDR = 16'h1000, DBG_ADDR = 16'h0000;
   dbg_op_t DBG_OP = DBG_READ;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RAM_WR, RAM_RD;
   logic CR_ACK, STALL, FLASH_ERR_RST, DBG_READY, DBG_DONE, DBG_REFUSED;
   logic DM_WR, DM_RD, CR_REQ;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   logic [15:0] RAM_ADDR, DM_ADDR, CR_ADDR;
   logic [7:0] RAM_WDATA, DM_WDATA, CR_DATA, DBG_RDATA;
   int n_mismatch = 0, checked = 0, n_err = 0, n_stall = 0;
   logic [15:0] pa;
   logic [7:0] d1, d2, q;
   flash_program_erase_security #(.ERASE_CYCLES(EC)) DUT (
      .CLK, .RST_N, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY,
      .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
      .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP, .DM_WR, .DM_RD,
      .DM_ADDR, .DM_WDATA, .RAM_WR, .RAM_RD, .RAM_ADDR, .RAM_WDATA,
      .CR_REQ, .CR_ADDR, .CR_ACK, .CR_DATA, .EXEC_ADDR, .STALL,
      .FLASH_ERR_RST, .DBG_REQ, .DBG_OP, .DBG_ADDR, .DBG_WDATA,
      .DBG_READY, .DBG_DONE, .DBG_REFUSED, .DBG_RDATA);
   cpu_core_model cpu (.clk(CLK), .stall(STALL), .cr_ack(CR_ACK),
      .cr_data(CR_DATA), .dm_wr(DM_WR), .dm_rd(DM_RD), .dm_addr(DM_ADDR),
      .dm_wdata(DM_WDATA), .cr_req(CR_REQ), .cr_addr(CR_ADDR));
   always #20 CLK = ~CLK;
   always @(posedge CLK)
   begin
      n_err <= n_err + int'(FLASH_ERR_RST === 1'b1);
      n_stall <= n_stall + int'(STALL === 1'b1);
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic [7:0] progd(input logic [7:0] o,
                                        input logic [7:0] d);
      return o & d;
   endfunction
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      AWADDR <= a;
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge CLK);
         if (AWVALID && AWREADY)
            aw = 1'b1;
         if (WVALID && WREADY)
            w = 1'b1;
         AWVALID <= !aw;
         WVALID <= !w;
      end
      BREADY <= 1'b1;
      do @(posedge CLK); while (!BVALID);
      BREADY <= 1'b0;
      chk({30'h0, BRESP}, {30'h0, r});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
      ARADDR <= a;
      ARVALID <= 1'b1;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      RREADY <= 1'b1;
      do @(posedge CLK); while (!RVALID);
      RREADY <= 1'b0;
      chk(RDATA, e);
      chk({30'h0, RRESP}, {30'h0, r});
   endtask
   // random gap between the codes: any spacing must be accepted
   task automatic key(input logic [7:0] k1, input logic [7:0] k2);
      wr(`KEY_OFS, k1, `RESP_OKAY);
      repeat ($urandom_range(5)) @(posedge CLK);
      wr(`KEY_OFS, k2, `RESP_OKAY);
   endtask
   task automatic fw(input logic [15:0] a, input logic [7:0] d,
                     input int s);
      int s0;
      s0 = n_stall;
      cpu.req(2'd1, a, d, q);
      if (s >= 0)
         chk(32'(n_stall - s0), 32'(s));
   endtask
   task automatic cr(input logic [15:0] a, input logic [7:0] e);
      cpu.req(2'd3, a, 8'h00, q);
      chk({24'h0, q}, {24'h0, e});
   endtask
   task automatic dbg(input dbg_op_t o, input logic [15:0] a,
                      input logic f, input logic [7:0] e);
      DBG_OP <= o;
      DBG_ADDR <= a;
      DBG_REQ <= 1'b1;
      do @(posedge CLK); while (!DBG_READY);
      DBG_REQ <= 1'b0;
      DBG_ADDR <= ~a;
      do @(posedge CLK); while (!DBG_DONE);
      chk({31'h0, DBG_REFUSED}, {31'h0, f});
      if (!f && o == DBG_READ)
         chk({24'h0, DBG_RDATA}, {24'h0, e});
      while (STALL) @(posedge CLK);
   endtask
   task automatic rst();
      RST_N <= 1'b0;
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge CLK);
      while (STALL) @(posedge CLK);
   endtask
   initial
   begin
      repeat (60000) @(posedge CLK);
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      int e0;
      void'($urandom(32'hff39));
      rst();
      rd(`CTL_OFS, 32'h0, `RESP_OKAY);
      rd(`STAT_OFS, 32'h0000ff00, `RESP_OKAY);
      rd(`RSRC_OFS, 32'h0, `RESP_OKAY);
      rd(8'h10, 32'h0, `RESP_SLVERR);
      wr(8'h10, 8'h01, `RESP_SLVERR);
      pa = 16'h1000 | 16'($urandom_range(16'h0fff));
      d1 = 8'($urandom);
      cpu.req(2'd1, pa, d1, q);
      chk({8'h0, RAM_WDATA, RAM_ADDR}, {8'h0, d1, pa});
      wr(`CTL_OFS, 8'h01, `RESP_OKAY);
      cpu.req(2'd2, pa ^ 16'h0001, 8'h00, q);
      chk({16'h0, RAM_ADDR}, {16'h0, pa ^ 16'h0001});
      for (int k = 0; k < 2; k++)
      begin
         pa = {4'h1, k[0], 11'($urandom)};
         d1 = 8'($urandom);
         d2 = 8'($urandom);
         key(`KEY_CODE1, `KEY_CODE2);
         rd(`STAT_OFS, 32'h0000ff02, `RESP_OKAY);
         fw(pa, d1, 1000);
         rd(`STAT_OFS, 32'h0000ff00, `RESP_OKAY);
         rd(`CTL_OFS, 32'h1, `RESP_OKAY);
         cr(pa, d1);
         key(`KEY_CODE1, `KEY_CODE2);
         fw(pa, d2, 1000);
         cr(pa, progd(d1, d2));
      end
      wr(`CTL_OFS, 8'h03, `RESP_OKAY);
      key(`KEY_CODE1, `KEY_CODE2);
      fw(pa ^ 16'($urandom_range(16'h01ff)), 8'h00, EC);
      cr(pa, `ERASED_BYTE);
      wr(`CTL_OFS, 8'h00, `RESP_OKAY);
      wr(`CTL_OFS, 8'h01, `RESP_OKAY);
      fw(pa, 8'h00, 0);
      key(`KEY_CODE1, `KEY_CODE2);
      rd(`STAT_OFS, 32'h0000ff04, `RESP_OKAY);
      fw(pa, 8'h00, 0);
      cr(pa, `ERASED_BYTE);
      for (int k = 0; k < 3; k++)
      begin
         rst();
         key(B1[8*k +: 8], B2[8*k +: 8]);
         rd(`STAT_OFS, 32'h0000ff04, `RESP_OKAY);
      end
      rst();
      wr(`CTL_OFS, 8'h01, `RESP_OKAY);
      key(`KEY_CODE1, `KEY_CODE2);
      fw({2'b00, `LOCK_ADDR}, 8'hfe, 1000);
      rst();
      rd(`STAT_OFS, 32'h0000fe08, `RESP_OKAY);
      e0 = n_err;
      dbg(DBG_READ, 16'h0010, 1'b1, 8'h00);
      dbg(DBG_READ, 16'h3d00, 1'b1, 8'h00);
      dbg(DBG_READ, 16'h0400, 1'b0, 8'hff);
      d1 = 8'($urandom);
      DBG_WDATA <= d1;
      fork
         dbg(DBG_WRITE, 16'h0400, 1'b0, 8'h00);
         begin
            repeat (4) @(posedge CLK);
            cpu.req(2'd2, pa, 8'h00, q);
         end
      join
      chk({16'h0, RAM_ADDR}, {16'h0, pa});
      dbg(DBG_READ, 16'h0400, 1'b0, progd(`ERASED_BYTE, d1));
      dbg(DBG_WRITE, {2'b00, `LOCK_ADDR}, 1'b1, 8'h00);
      dbg(DBG_READ, `RSVD_BASE, 1'b1, 8'h00);
      dbg(DBG_ERASE, 16'h3c00, 1'b1, 8'h00);
      chk(32'(n_err - e0), 32'h0);
      EXEC_ADDR <= 16'h0000;
      cr(16'h0010, `ERASED_BYTE);
      EXEC_ADDR <= 16'h1000;
      wr(`CTL_OFS, 8'h03, `RESP_OKAY);
      key(`KEY_CODE1, `KEY_CODE2);
      cr(16'h0010, 8'h00);
      chk(32'(n_err - e0), 32'h1);
      rd(`RSRC_OFS, 32'h1, `RESP_OKAY);
      rd(`CTL_OFS, 32'h0, `RESP_OKAY);
      rd(`STAT_OFS, 32'h0000fe08, `RESP_OKAY);
      EXEC_ADDR <= 16'h0000;
      cr(`RSVD_BASE, 8'h00);
      chk(32'(n_err - e0), 32'h2);
      wr(`CTL_OFS, 8'h03, `RESP_OKAY);
      key(`KEY_CODE1, `KEY_CODE2);
      fw(16'h3c00, 8'h00, -1);
      chk(32'(n_err - e0), 32'h3);
      wr(`CTL_OFS, 8'h01, `RESP_OKAY);
      key(`KEY_CODE1, `KEY_CODE2);
      fw({2'b00, `LOCK_ADDR}, 8'h00, -1);
      chk(32'(n_err - e0), 32'h4);
      dbg(DBG_DEV_ERASE, 16'h0000, 1'b0, 8'h00);
      rd(`STAT_OFS, 32'h0000ff00, `RESP_OKAY);
      dbg(DBG_ERASE, 16'h3c00, 1'b0, 8'h00);
      tally_and_finish();
   end
endmodule
bind flash_program_erase_security flash_ctl_monitor
   #(.ERASE_CYCLES(ERASE_CYCLES)) u_mon (.CLK, .RST_N, .DM_WR, .DM_RD,
   .DM_ADDR, .RAM_WR, .RAM_RD, .RAM_ADDR, .CR_REQ, .CR_ACK, .STALL,
   .FLASH_ERR_RST, .DBG_REQ, .DBG_OP, .DBG_READY, .DBG_DONE,
   .DBG_REFUSED);
`default_nettype wire
